/* hw/bie_consts.svh */
// Purpose: offsets, field positions, reset values and vector offsets of the entry unit
// Assumes: included by the design module and by the bench
// Notes: register offsets are byte addresses on the register bus
`ifndef BIE_CONSTS_SVH
`define BIE_CONSTS_SVH

// ==========================================================
// register map
`define BIE_OFS_STATUS_WORD 4'h0
`define BIE_OFS_PENDING 4'h4

// ==========================================================
// status word fields
`define BIE_BIT_IE 0
`define BIE_BIT_BIP 1
`define BIE_BIT_EIP 2
`define BIE_BIT_EE 3
`define BIE_BIT_UM 4
`define BIE_BIT_UMS 5
`define BIE_BIT_VM 6
`define BIE_BIT_VMS 7
`define BIE_MSW_RESET 8'h00

// pending register fields
`define BIE_BIT_PEND_IRQ 0
`define BIE_BIT_PEND_NMB 1

// ==========================================================
// vector offsets, link registers and acknowledge codes
`define BIE_VEC_USER 32'h0000_0008
`define BIE_VEC_IRQ 32'h0000_0010
`define BIE_VEC_BRK 32'h0000_0018
`define BIE_BRKI_DEBUG 32'h0000_0018
`define BIE_LINK_BRK 5'h10
`define BIE_LINK_IRQ 5'h0E
`define BIE_ACK_IDLE 2'h0
`define BIE_ACK_JUMP 2'h1
`define BIE_ACK_RETURN 2'h2
`define BIE_ACK_ENABLE 2'h3

`endif

/* hw/bie_pkg.sv */
// Purpose: types shared by the break and interrupt entry unit
// Assumes: nothing
// Notes: numeric values live in bie_consts.svh
package bie_pkg;
	// ==========================================================
	// redirect and link write that the pipeline applies
	typedef struct packed {
		logic valid;      // replace decode instruction with a jump
		logic [31:0] pc;  // jump target
		logic link_we;    // write return address to a register
		logic [4:0] link_idx;
		logic [31:0] link_data;
	} bie_redirect_s;

	// machine status word flags
	typedef struct packed {
		logic saved_virtual_mode_flag;
		logic vm;
		logic saved_user_mode_flag;
		logic um;
		logic ee;
		logic exception_active_flag;
		logic break_active_flag;
		logic ie;
	} bie_msw_s;
endpackage

/* hw/bie_entry.sv */
// Purpose: break, interrupt and user-vector entry of the processor core
// Assumes: break and interrupt sources run on core_clk; pipeline events are one-cycle pulses
// Notes: status word is also reached over an Avalon-MM slave with waitrequest
// Contract
// - taken break jumps to base plus 0x18
// - break return address goes to register 16
// - taken break sets break_active_flag
// - entries save and clear mode flags, reservation
// - external break only when no break/exception active
// - nonmaskable break always taken immediately; held until decode_valid while decode stalls
// - return_from_break_instr clears break_active_flag
// - debug brki to 0x18 signals software breakpoint
// - interrupt only while interrupt_enable_flag set
// - interrupt jumps to base plus 0x10 or vector
// - interrupt links register 14, clears enable
// - return_from_irq_instr sets interrupt_enable_flag
// - interrupt ignored during break or exception
// - parameter selects level or edge interrupt
// - rising edge latched; low cycle needed between
// - edge latched while disabled, served on enable
// - low-latency acknowledge codes 01, 10, 11
// - acknowledge code lasts one cycle, then 00
// - branch-link to 0x8 enters user vector
// - exception flag; return restores enable, clears flag
// - all three returns restore mode flags
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "bie_consts.svh"

module bie_entry
	import bie_pkg::*;
#(
	parameter logic [31:0] vector_base_param = 32'h0000_0000,
	parameter bit irq_edge_select_param = 1'b0,  // 0 level, 1 rising edge
	parameter bit low_latency_param = 1'b0,      // vector from controller, acknowledge codes
	parameter bit debug_enable_param = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// break and interrupt sources
	input wire logic external_break_request,
	input wire logic nonmaskable_break_request,
	input wire logic irq_request,
	input wire logic [31:0] irq_vector_input,
	output logic [1:0] irq_handshake_code,
	// pipeline side
	input wire logic decode_valid,
	input wire logic [31:0] decode_pc,
	input wire logic user_vector_req,
	input wire logic [4:0] user_vector_link,
	input wire logic brki_exec,
	input wire logic [31:0] brki_target,
	input wire logic return_from_break_instr,
	input wire logic return_from_irq_instr,
	input wire logic return_from_exception_instr,
	input wire logic exception_entry,
	output bie_redirect_s redirect,
	output logic reservation_clear,
	output logic sw_breakpoint,
	output bie_msw_s machine_status_word,
	// register bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ==========================================================
	// state
	bie_msw_s msw_q, msw_d;         // live status word
	logic nmb_pend_q, nmb_pend_d;   // nonmaskable request not yet taken
	logic irq_prev_q, irq_prev_d;   // last sample of the interrupt input
	logic edge_pend_q, edge_pend_d; // latched rising edge
	bie_redirect_s redir_q, redir_d;
	logic resv_q, resv_d;
	logic swbk_q, swbk_d;
	logic [1:0] ack_q, ack_d;
	logic bus_ack_q, bus_ack_d;     // second cycle of a bus access
	logic [31:0] rdata_q, rdata_d;

	// decisions of this cycle
	logic nmb_now;
	logic brk_take;
	logic irq_pending;
	logic irq_take;
	logic uvec_take;
	logic entry;
	logic bus_wr;

	// ==========================================================
	// arbitration
	// a nonmaskable pulse that meets a busy decode stage is kept until it can be taken
	always_comb begin
		nmb_now = nonmaskable_break_request | nmb_pend_q;
		// external break needs a quiet machine; nonmaskable ignores the flags
		brk_take = decode_valid & (nmb_now |
			(external_break_request & ~msw_q.break_active_flag & ~msw_q.exception_active_flag));
		// edge mode serves the latch, level mode reads the input directly
		irq_pending = irq_edge_select_param ? edge_pend_q : irq_request;
		// break first: its flag then blocks the interrupt, which stays pending
		irq_take = decode_valid & irq_pending & msw_q.ie & ~msw_q.break_active_flag & ~msw_q.exception_active_flag
			& ~brk_take;
		// user vector is the lowest of the three entries
		uvec_take = decode_valid & user_vector_req & ~brk_take & ~irq_take;
		entry = brk_take | irq_take | uvec_take;
	end

	// ==========================================================
	// pending latches
	always_comb begin
		// a pulse taken in its own cycle is spent; one meeting a stalled decode stage
		// waits here, so a single request never produces two entries
		nmb_pend_d = nmb_now & ~brk_take;
		irq_prev_d = irq_request;
		// the input must be seen low before a new edge counts
		edge_pend_d = (irq_request & ~irq_prev_q) | (edge_pend_q & ~irq_take);
	end

	// latches clear on reset so no stale request fires after release
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			nmb_pend_q <= 1'b0;
			irq_prev_q <= 1'b0;
			edge_pend_q <= 1'b0;
		end else begin
			nmb_pend_q <= nmb_pend_d;
			irq_prev_q <= irq_prev_d;
			edge_pend_q <= edge_pend_d;
		end
	end

	// ==========================================================
	// status word: bus write, then returns, then entries, last wins
	always_comb begin
		msw_d = msw_q;
		// software may rewrite every flag; hardware events below override it
		if (bus_wr && avs_address == `BIE_OFS_STATUS_WORD) begin
			msw_d = bie_msw_s'(avs_writedata[7:0]);
		end
		// any return puts the saved modes back
		if (return_from_break_instr || return_from_irq_instr ||
			return_from_exception_instr) begin
			msw_d.um = msw_q.saved_user_mode_flag;
			msw_d.vm = msw_q.saved_virtual_mode_flag;
		end
		if (return_from_break_instr) begin
			msw_d.break_active_flag = 1'b0;
		end
		if (return_from_irq_instr) begin
			msw_d.ie = 1'b1;
		end
		if (return_from_exception_instr) begin
			msw_d.ee = 1'b1;
			msw_d.exception_active_flag = 1'b0;
		end
		// exception entry itself is decided elsewhere; only its flags live here
		if (exception_entry) begin
			msw_d.exception_active_flag = 1'b1;
			msw_d.ee = 1'b0;
		end
		if (entry || exception_entry) begin
			msw_d.saved_user_mode_flag = msw_q.um;
			msw_d.um = 1'b0;
			msw_d.saved_virtual_mode_flag = msw_q.vm;
			msw_d.vm = 1'b0;
		end
		if (brk_take) begin
			msw_d.break_active_flag = 1'b1;
		end
		if (irq_take) begin
			msw_d.ie = 1'b0;
		end
	end

	// status word resets to all flags clear: interrupts start disabled
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			msw_q <= bie_msw_s'(`BIE_MSW_RESET);
		end else begin
			msw_q <= msw_d;
		end
	end

	// ==========================================================
	// redirect, link write, reservation, debug and acknowledge outputs
	always_comb begin
		redir_d = '0;
		if (brk_take) begin
			redir_d.valid = 1'b1;
			redir_d.pc = vector_base_param + `BIE_VEC_BRK;
			redir_d.link_we = 1'b1;
			redir_d.link_idx = `BIE_LINK_BRK;
			redir_d.link_data = decode_pc;
		end else if (irq_take) begin
			redir_d.valid = 1'b1;
			// low-latency mode jumps straight to the controller's handler
			redir_d.pc = low_latency_param ? irq_vector_input :
				vector_base_param + `BIE_VEC_IRQ;
			redir_d.link_we = 1'b1;
			redir_d.link_idx = `BIE_LINK_IRQ;
			redir_d.link_data = decode_pc;
		end else if (uvec_take) begin
			redir_d.valid = 1'b1;
			redir_d.pc = vector_base_param + `BIE_VEC_USER;
			redir_d.link_we = 1'b1;
			redir_d.link_idx = user_vector_link;
			redir_d.link_data = decode_pc;
		end
		// one clear of the exclusive reservation per entry
		resv_d = entry;
		// debug breakpoint is tied to the fixed target, not to the vector base
		swbk_d = debug_enable_param & brki_exec & (brki_target == `BIE_BRKI_DEBUG);
		// each code is a single-cycle pulse, idle otherwise
		ack_d = `BIE_ACK_IDLE;
		if (low_latency_param) begin
			if (irq_take) begin
				ack_d = `BIE_ACK_JUMP;
			end else if (return_from_irq_instr) begin
				ack_d = `BIE_ACK_RETURN;
			end else if (!msw_q.ie && msw_d.ie) begin
				ack_d = `BIE_ACK_ENABLE;
			end
		end
	end

	// registered so the pipeline and controller see clean one-cycle pulses
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			redir_q <= '0;
			resv_q <= 1'b0;
			swbk_q <= 1'b0;
			ack_q <= `BIE_ACK_IDLE;
		end else begin
			redir_q <= redir_d;
			resv_q <= resv_d;
			swbk_q <= swbk_d;
			ack_q <= ack_d;
		end
	end

	// ==========================================================
	// register bus slave: every access takes exactly two cycles
	always_comb begin
		bus_ack_d = (avs_read | avs_write) & ~bus_ack_q;
		bus_wr = avs_write & bus_ack_q; // takes effect at the released edge
		// read data is captured in the waiting cycle so it stands when waitrequest drops
		rdata_d = rdata_q;
		if (avs_read && !bus_ack_q) begin
			if (avs_address == `BIE_OFS_STATUS_WORD) begin
				rdata_d = {24'h00_0000, msw_q};
			end else if (avs_address == `BIE_OFS_PENDING) begin
				rdata_d = 32'h0000_0000;
				rdata_d[`BIE_BIT_PEND_IRQ] = irq_pending;
				rdata_d[`BIE_BIT_PEND_NMB] = nmb_pend_q;
			end else begin
				rdata_d = 32'h0000_0000; // unmapped reads as zero
			end
		end
	end

	// readdata keeps its last value between reads
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_ack_q <= bus_ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// outputs
	// every output comes straight from a flip-flop except waitrequest
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
	assign avs_readdata = rdata_q;
	assign redirect = redir_q;
	assign reservation_clear = resv_q;
	assign sw_breakpoint = swbk_q;
	assign irq_handshake_code = ack_q;
	assign machine_status_word = msw_q;

	// ==========================================================
	// checks
	// all checks run on core_clk and rest while reset is held
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_brk_vector_jump: assert property (brk_take |=> redirect.valid &&
		redirect.pc == vector_base_param + `BIE_VEC_BRK)
		else $error("break did not jump to break vector");
	a_brk_link_save: assert property (brk_take |=> redirect.link_idx == `BIE_LINK_BRK
		&& redirect.link_data == $past(decode_pc))
		else $error("break return address not saved");
	a_brk_flag_set: assert property (brk_take |=> machine_status_word.break_active_flag)
		else $error("break flag not set");
	a_entry_mode_save: assert property (entry |=> !machine_status_word.um &&
		!machine_status_word.vm && machine_status_word.saved_user_mode_flag == $past(msw_q.um) &&
		reservation_clear)
		else $error("entry mode save wrong");
	a_ext_brk_gate: assert property ((msw_q.break_active_flag || msw_q.exception_active_flag) && !nmb_now |-> !brk_take)
		else $error("external break taken while busy");
	a_nmb_immediate: assert property (nonmaskable_break_request && decode_valid
		|-> brk_take)
		else $error("nonmaskable break not taken");
	a_return_from_break_instr_clear: assert property (return_from_break_instr && !brk_take
		&& !bus_wr |=> !machine_status_word.break_active_flag)
		else $error("break flag not cleared");
	a_sw_bkpt: assert property (debug_enable_param && brki_exec &&
		brki_target == `BIE_BRKI_DEBUG |=> sw_breakpoint)
		else $error("software breakpoint missed");
	a_irq_gating: assert property (irq_take |-> msw_q.ie && !msw_q.break_active_flag && !msw_q.exception_active_flag)
		else $error("interrupt taken while blocked");
	a_irq_entry: assert property (irq_take |=> redirect.link_idx == `BIE_LINK_IRQ &&
		!machine_status_word.ie && redirect.pc == (low_latency_param ?
		$past(irq_vector_input) : vector_base_param + `BIE_VEC_IRQ))
		else $error("interrupt entry wrong");
	a_return_from_irq_instr_enable: assert property (return_from_irq_instr && !entry |=>
		machine_status_word.ie)
		else $error("interrupt enable not restored");
	a_edge_latch: assert property (irq_request && !irq_prev_q |=> edge_pend_q)
		else $error("rising edge not latched");
	a_ack_single: assert property (irq_handshake_code == `BIE_ACK_JUMP |=>
		irq_handshake_code != `BIE_ACK_JUMP)
		else $error("acknowledge held too long");
	a_ack_jump: assert property (low_latency_param && irq_take |=>
		irq_handshake_code == `BIE_ACK_JUMP)
		else $error("jump acknowledge missing");
	a_return_from_exception_instr_restore: assert property (return_from_exception_instr && !exception_entry
		&& !entry && !bus_wr |=> !machine_status_word.exception_active_flag && machine_status_word.ee &&
		machine_status_word.um == $past(msw_q.saved_user_mode_flag))
		else $error("exception return wrong");
	a_break_priority: assert property (brk_take |-> !irq_take)
		else $error("interrupt beat break");
	// pending nonmaskable request must not outlive its own take
	a_nmb_single_take: assert property (brk_take |=> !nmb_pend_q)
		else $error("nonmaskable request taken twice");
	// a break that wins keeps the latched edge for later
	a_brk_keeps_edge: assert property (brk_take && edge_pend_q |=> edge_pend_q)
		else $error("pending interrupt lost to break");
	// level mode serves a held input at once when the machine is open
	a_level_irq_take: assert property (!irq_edge_select_param && irq_request
		&& decode_valid && msw_q.ie && !msw_q.break_active_flag && !msw_q.exception_active_flag && !brk_take
		|-> irq_take)
		else $error("level interrupt not taken");
	// edge mode needs a latched edge before any take
	a_edge_needs_latch: assert property (irq_edge_select_param && !edge_pend_q
		|-> !irq_take)
		else $error("edge interrupt taken without edge");
	// user vector jumps to base plus 0x8 and links the chosen register
	a_uvec_entry: assert property (uvec_take |=> redirect.valid &&
		redirect.pc == vector_base_param + `BIE_VEC_USER &&
		redirect.link_idx == $past(user_vector_link))
		else $error("user vector entry wrong");
	// break and interrupt returns bring the saved modes back
	a_return_modes: assert property ((return_from_break_instr ||
		return_from_irq_instr) && !entry && !exception_entry |=>
		machine_status_word.um == $past(msw_q.saved_user_mode_flag) && machine_status_word.vm == $past(msw_q.saved_virtual_mode_flag))
		else $error("saved modes not restored");
	// return and re-enable codes reach the controller one edge later
	a_ack_return: assert property (low_latency_param && return_from_irq_instr
		&& !irq_take |=> irq_handshake_code == `BIE_ACK_RETURN)
		else $error("return acknowledge missing");
	a_ack_enable: assert property (low_latency_param && $rose(machine_status_word.ie)
		&& !$past(return_from_irq_instr) |-> irq_handshake_code == `BIE_ACK_ENABLE)
		else $error("enable acknowledge missing");
	// without low-latency mode the acknowledge lines stay idle
	a_ack_idle: assert property (!low_latency_param |->
		irq_handshake_code == `BIE_ACK_IDLE)
		else $error("acknowledge driven in plain mode");

endmodule

/* test/bie_source_model.sv */
// Purpose: break sources and low-latency interrupt controller facing the entry unit
// Assumes: one-cycle commands from the bench on core_clk
// Notes: vector line is a driven bus, so it always carries the handler address
`timescale 1ns/1ps

module bie_source_model #(
	parameter bit edge_mode = 1'h1,
	parameter logic [31:0] vector_value = 32'h0000_2400
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [2:0] go,
	input wire logic break_taken,
	input wire logic irq_taken,
	output logic external_break_request,
	output logic nonmaskable_break_request,
	output logic irq_request,
	output logic [31:0] irq_vector_input
);
	// ==========================================================
	// request lines
	assign irq_vector_input = vector_value;

	// go[0] external break, go[1] nonmaskable break, go[2] interrupt
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			external_break_request <= 1'h0;
			nonmaskable_break_request <= 1'h0;
			irq_request <= 1'h0;
		end else begin
			// held until the flag shows the break taken, so dropped before the break's own return
			if (go[0]) begin
				external_break_request <= 1'h1;
			end else if (break_taken) begin
				external_break_request <= 1'h0;
			end
			nonmaskable_break_request <= go[1];
			// edge mode: one-cycle pulse, low again before the next edge
			if (edge_mode) begin
				irq_request <= go[2];
			end else if (go[2]) begin
				irq_request <= 1'h1;
			end else if (irq_taken) begin
				irq_request <= 1'h0;
			end
		end
	end
endmodule

/* test/bie_entry_bench.sv */
// Purpose: self-checking bench of the entry unit, edge and low-latency build
// Assumes: bus master waits on waitrequest; pipeline events are one-cycle pulses
// Notes: monitors count redirects, acknowledge codes and pulses at negedge
`timescale 1ns/1ps
`include "bie_consts.svh"

module bie_entry_bench
	import bie_pkg::*;
();
	// ==========================================================
	// signals
	localparam logic [31:0] base_addr = 32'h0000_1000;
	localparam logic [31:0] irq_vec = 32'h0000_2400;
	logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic ext_brk, nm_brk, irq_req, res_clr, sw_bp, dv;
	logic [8:0] pls; // pipeline events and source commands
	logic [31:0] decode_pc, brki_target, avs_writedata, avs_readdata, irq_in, rdv;
	logic [4:0] user_vector_link;
	logic [3:0] avs_address;
	logic [1:0] ack_code, ack_prev;
	bie_redirect_s redirect, last_redir;
	bie_msw_s msw;
	int n_mismatch, n_checks, n_redir, n_rc, n_sw, r0;
	int ack_n [4];

	bie_entry #(.vector_base_param(base_addr), .irq_edge_select_param(1'h1),
		.low_latency_param(1'h1), .debug_enable_param(1'h1)) bie_entry_inst (
		.core_clk(core_clk), .rst_b(rst_b), .external_break_request(ext_brk),
		.nonmaskable_break_request(nm_brk), .irq_request(irq_req),
		.irq_vector_input(irq_in), .irq_handshake_code(ack_code),
		.decode_valid(dv), .decode_pc(decode_pc), .user_vector_req(pls[0]),
		.user_vector_link(user_vector_link), .brki_exec(pls[1]), .brki_target(brki_target),
		.return_from_break_instr(pls[2]), .return_from_irq_instr(pls[3]),
		.return_from_exception_instr(pls[4]), .exception_entry(pls[5]),
		.redirect(redirect), .reservation_clear(res_clr), .sw_breakpoint(sw_bp),
		.machine_status_word(msw), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	bie_source_model #(.edge_mode(1'h1), .vector_value(irq_vec)) bie_source_model_inst (
		.core_clk(core_clk), .rst_b(rst_b), .go(pls[8:6]), .break_taken(msw.break_active_flag),
		.irq_taken(redirect.valid && redirect.link_idx == `BIE_LINK_IRQ),
		.external_break_request(ext_brk), .nonmaskable_break_request(nm_brk),
		.irq_request(irq_req), .irq_vector_input(irq_in));

	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	// ==========================================================
	// tasks
	task final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until waitrequest is sampled low at a rising edge, released after it
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'h0 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 50) n_mismatch++;
		rdv = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask

	task rdc(input logic [3:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(rdv, exp);
	endtask

	// one-cycle event on pls[i] with a fresh decode pc
	task go(input int i, input logic [31:0] pc);
		r0 = n_redir;
		@(posedge core_clk);
		decode_pc <= pc;
		pls[i] <= 1'h1;
		@(posedge core_clk);
		pls[i] <= 1'h0;
	endtask

	task expect_redir(input logic [31:0] pc, input logic [4:0] idx, input logic [31:0] data);
		int n;
		n = 0;
		while (n_redir == r0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		chk(n_redir, r0 + 1);
		chk(last_redir.pc, pc);
		chk({27'h0, last_redir.link_idx}, {27'h0, idx});
		chk({31'h0, last_redir.link_we}, 32'h1);
		chk(last_redir.link_data, data);
	endtask

	task expect_none;
		repeat (10) @(negedge core_clk);
		chk(n_redir, r0);
	endtask

	// ==========================================================
	// monitor: count outputs once per cycle where they are settled
	always @(negedge core_clk) begin
		if (rst_b === 1'h1) begin
			if (redirect.valid === 1'h1) begin
				n_redir++;
				last_redir = redirect;
			end
			if (res_clr === 1'h1) n_rc++;
			if (sw_bp === 1'h1) n_sw++;
			if (ack_code !== 2'h0) begin
				ack_n[ack_code]++;
				chk({31'h0, ack_code === ack_prev}, 32'h0);
			end
			ack_prev = ack_code;
		end
	end

	initial begin
		#(2000 * 100);
		n_mismatch++;
		final_report();
	end

	// ==========================================================
	// tests
	initial begin
		rst_b = 1'h0;
		pls = 9'h0;
		dv = 1'h1;
		decode_pc = 32'h0;
		brki_target = `BIE_BRKI_DEBUG;
		user_vector_link = 5'h0F;
		avs_address = 4'h0;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0;
		ack_prev = 2'h0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'h1;
		rdc(`BIE_OFS_STATUS_WORD, 32'h0);
		bus(1'h1, `BIE_OFS_PENDING, 32'h3);
		rdc(`BIE_OFS_PENDING, 32'h0);
		rdc(4'hC, 32'h0);
		bus(1'h1, `BIE_OFS_STATUS_WORD, 32'h51);
		rdc(`BIE_OFS_STATUS_WORD, 32'h51);
		chk(ack_n[3], 1);
		go(6, 32'h100);
		expect_redir(base_addr + `BIE_VEC_BRK, `BIE_LINK_BRK, 32'h100);
		rdc(`BIE_OFS_STATUS_WORD, 32'hA3);
		chk(n_rc, 1);
		// edge while a break is active: latched, not served
		go(8, 32'h180);
		expect_none();
		rdc(`BIE_OFS_PENDING, 32'h1);
		go(7, 32'h200);
		expect_redir(base_addr + `BIE_VEC_BRK, `BIE_LINK_BRK, 32'h200);
		rdc(`BIE_OFS_STATUS_WORD, 32'h03);
		// leaving the break releases the pending edge to the controller vector
		go(2, 32'h300);
		expect_redir(irq_vec, `BIE_LINK_IRQ, 32'h300);
		rdc(`BIE_OFS_STATUS_WORD, 32'h00);
		chk(ack_n[1], 1);
		go(3, 32'h380);
		rdc(`BIE_OFS_STATUS_WORD, 32'h01);
		chk(ack_n[2], 1);
		chk(ack_n[3], 1);
		// edge captured while disabled, served once enabled by software
		bus(1'h1, `BIE_OFS_STATUS_WORD, 32'h0);
		go(8, 32'h400);
		expect_none();
		bus(1'h1, `BIE_OFS_STATUS_WORD, 32'h1);
		expect_redir(irq_vec, `BIE_LINK_IRQ, 32'h400);
		chk(ack_n[3], 2);
		go(0, 32'h500);
		expect_redir(base_addr + `BIE_VEC_USER, 5'h0F, 32'h500);
		chk(n_rc, 5);
		go(1, 32'h580);
		brki_target <= 32'h0000_0020;
		go(1, 32'h580);
		repeat (3) @(posedge core_clk);
		chk(n_sw, 1);
		// external break refused during an exception, taken after its return
		go(5, 32'h600);
		rdc(`BIE_OFS_STATUS_WORD, 32'h04);
		go(6, 32'h700);
		expect_none();
		go(4, 32'h700);
		expect_redir(base_addr + `BIE_VEC_BRK, `BIE_LINK_BRK, 32'h700);
		rdc(`BIE_OFS_STATUS_WORD, 32'h0A);
		go(2, 32'h800);
		rdc(`BIE_OFS_STATUS_WORD, 32'h08);
		chk({24'h0, msw}, 32'h08);
		// nonmaskable pulse meeting a stalled decode stage waits, then is taken once
		dv <= 1'h0;
		go(7, 32'h900);
		repeat (3) @(posedge core_clk);
		rdc(`BIE_OFS_PENDING, 32'h2);
		dv <= 1'h1;
		expect_redir(base_addr + `BIE_VEC_BRK, `BIE_LINK_BRK, 32'h900);
		repeat (5) @(negedge core_clk);
		chk(n_redir, r0 + 1);
		rdc(`BIE_OFS_STATUS_WORD, 32'h0A);
		final_report();
	end
endmodule
